// ---- msia_irq_dev.sv ----
// Interrupt request logic: four multi-source interrupts, two address-match
// interrupts, acknowledge read at index 0 and the stack pointer.
// Assumes the controller end shares pclk and drives the link from flops.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module msia_irq_dev (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Link to controller
  msia_link_if.dev lnk
);
  logic [7:0] stat_ff [msia_pkg::NUM_MS];
  logic [7:0] en_ff [msia_pkg::NUM_MS];
  logic [2:0] lvl_ff [msia_pkg::NUM_MS];
  logic [3:0] flag_ff;
  logic [1:0] men_ff;
  logic [19:0] madr_ff [msia_pkg::NUM_MATCH];
  logic [1:0] mpend_ff;
  logic [19:0] spc_ff;
  logic [15:0] sp_ff;
  logic sp_set_ff;
  logic done_ff;
  logic [31:0] rdata_ff;
  logic irq_req_ff;
  logic [2:0] irq_num_ff;
  logic [2:0] irq_lvl_ff;
  logic acc;
  logic wr_go;
  logic ack_rd;
  logic win_ok;
  logic [1:0] win_idx;
  logic [2:0] win_lvl;
  logic m_any;
  logic m_idx;
  logic [1:0] m_hit;
  logic [31:0] nxt_rdata;
  logic [7:0] nxt_stat [msia_pkg::NUM_MS];

  // Generic modify of a field by plain move, bit set or bit clear
  function automatic logic [31:0] modify(input logic [31:0] old, input logic [31:0] wd,
                                         input msia_pkg::msia_op_t op);
    case (op)
      msia_pkg::OP_WR: modify = wd;
      msia_pkg::OP_SET: modify = old | wd;
      msia_pkg::OP_CLR: modify = old & ~wd;
      default: modify = old;
    endcase
  endfunction

  // One access per request; done_ff blocks a second take while req is held
  assign acc = lnk.reg_req && !done_ff;
  assign wr_go = acc && (lnk.reg_op != msia_pkg::OP_RD);
  assign ack_rd = acc && (lnk.reg_op == msia_pkg::OP_RD) && (lnk.reg_addr == msia_pkg::IDX_ACK);
  assign m_any = |mpend_ff;
  assign m_idx = !mpend_ff[0];

  // Maskable arbitration: highest level above processor level, lower index on ties
  always_comb begin
    win_ok = 1'b0;
    win_idx = 2'h0;
    win_lvl = msia_pkg::LVL_RESET;
    for (int i = 0; i < msia_pkg::NUM_MS; i++) begin
      if (flag_ff[i] && lnk.gie && (lvl_ff[i] > lnk.ppl) && (!win_ok || lvl_ff[i] > win_lvl)) begin
        win_ok = 1'b1;
        win_idx = 2'(i);
        win_lvl = lvl_ff[i];
      end
    end
  end

  // Fetch compare against each enabled match address
  always_comb begin
    for (int i = 0; i < msia_pkg::NUM_MATCH; i++) begin
      m_hit[i] = lnk.fetch_valid && men_ff[i] && (lnk.fetch_addr == madr_ff[i]);
    end
  end

  // Next source status: peripheral events set, software clears; set wins
  always_comb begin
    for (int i = 0; i < msia_pkg::NUM_MS; i++) begin
      nxt_stat[i] = stat_ff[i];
      if (wr_go && lnk.reg_addr == 5'(msia_pkg::IDX_STAT0 + i)) begin
        // Plain move clears bits written 0; bit clear clears bits written 1
        if (lnk.reg_op == msia_pkg::OP_WR) nxt_stat[i] = stat_ff[i] & lnk.reg_wdata[7:0];
        if (lnk.reg_op == msia_pkg::OP_CLR) nxt_stat[i] = stat_ff[i] & ~lnk.reg_wdata[7:0];
      end
      if (lnk.evt_valid && lnk.evt_sel == 2'(i)) nxt_stat[i] = nxt_stat[i] | lnk.evt_bits;
    end
  end

  // Source status registers; an acknowledge never touches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < msia_pkg::NUM_MS; i++) stat_ff[i] <= msia_pkg::SRC_RESET;
    end else if (ce) begin
      for (int i = 0; i < msia_pkg::NUM_MS; i++) stat_ff[i] <= nxt_stat[i];
    end
  end

  // Source enables and priority levels; the flag bit of control is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < msia_pkg::NUM_MS; i++) begin
        en_ff[i] <= msia_pkg::SRC_RESET;
        lvl_ff[i] <= msia_pkg::LVL_RESET;
      end
    end else if (ce && wr_go) begin
      for (int i = 0; i < msia_pkg::NUM_MS; i++) begin
        if (lnk.reg_addr == 5'(msia_pkg::IDX_EN0 + i)) begin
          en_ff[i] <= 8'(modify(32'(en_ff[i]), lnk.reg_wdata, lnk.reg_op));
        end
        if (lnk.reg_addr == 5'(msia_pkg::IDX_CTL0 + i)) begin
          // Every write form touches only the level bits, so a request is never dropped
          lvl_ff[i] <= 3'(modify(32'(lvl_ff[i]), lnk.reg_wdata, lnk.reg_op));
        end
      end
    end
  end

  // Request flags follow status and enable every clock; writes cannot hold them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 4'h0;
    end else if (ce) begin
      for (int i = 0; i < msia_pkg::NUM_MS; i++) begin
        // Acknowledge read drops the winner for one clock only
        if (ack_rd && !m_any && win_ok && win_idx == 2'(i)) begin
          flag_ff[i] <= 1'b0;
        end else begin
          flag_ff[i] <= |(stat_ff[i] & en_ff[i]);
        end
      end
    end
  end

  // Match enables and addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      men_ff <= 2'h0;
      for (int i = 0; i < msia_pkg::NUM_MATCH; i++) madr_ff[i] <= msia_pkg::MADR_RESET;
    end else if (ce && wr_go) begin
      if (lnk.reg_addr == msia_pkg::IDX_MEN) begin
        men_ff <= 2'(modify(32'(men_ff), lnk.reg_wdata, lnk.reg_op));
      end
      for (int i = 0; i < msia_pkg::NUM_MATCH; i++) begin
        if (lnk.reg_addr == 5'(msia_pkg::IDX_MADR0 + i)) begin
          madr_ff[i] <= 20'(modify(32'(madr_ff[i]), lnk.reg_wdata, lnk.reg_op));
        end
      end
    end
  end

  // Match pending bits and the saved program counter; a new hit beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mpend_ff <= 2'h0;
      spc_ff <= msia_pkg::MADR_RESET;
    end else if (ce) begin
      for (int i = 0; i < msia_pkg::NUM_MATCH; i++) begin
        if (m_hit[i]) begin
          mpend_ff[i] <= 1'b1;
        end else if (ack_rd && m_idx == 1'(i)) begin
          mpend_ff[i] <= 1'b0;
        end
      end
      if (|m_hit) begin
        if (lnk.fetch_plus2) begin
          spc_ff <= lnk.fetch_addr + msia_pkg::PC_STEP_LONG;
        end else begin
          spc_ff <= lnk.fetch_addr + msia_pkg::PC_STEP_SHORT;
        end
      end
    end
  end

  // Stack pointer: zero after reset, requests held off until loaded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_ff <= msia_pkg::SP_RESET;
      sp_set_ff <= 1'b0;
    end else if (ce && wr_go && lnk.reg_addr == msia_pkg::IDX_SP) begin
      sp_ff <= 16'(modify(32'(sp_ff), lnk.reg_wdata, lnk.reg_op));
      sp_set_ff <= 1'b1;
    end
  end

  // Read multiplexer
  always_comb begin
    nxt_rdata = msia_pkg::WORD_RESET;
    if (lnk.reg_addr == msia_pkg::IDX_ACK) begin
      nxt_rdata[msia_pkg::ACK_VLD_BIT] = m_any || win_ok;
      nxt_rdata[msia_pkg::ACK_NUM_LSB +: 3] = m_any ? (msia_pkg::MATCH_NUM0 + 3'(m_idx))
                                                  : 3'(win_idx);
      nxt_rdata[msia_pkg::ACK_LVL_LSB +: 3] = m_any ? msia_pkg::MATCH_LVL : win_lvl;
    end
    for (int i = 0; i < msia_pkg::NUM_MS; i++) begin
      if (lnk.reg_addr == 5'(msia_pkg::IDX_STAT0 + i)) nxt_rdata[7:0] = stat_ff[i];
      if (lnk.reg_addr == 5'(msia_pkg::IDX_EN0 + i)) nxt_rdata[7:0] = en_ff[i];
      if (lnk.reg_addr == 5'(msia_pkg::IDX_CTL0 + i)) begin
        nxt_rdata[msia_pkg::CTL_LVL_LSB +: 3] = lvl_ff[i];
        nxt_rdata[msia_pkg::CTL_FLAG_BIT] = flag_ff[i];
      end
    end
    if (lnk.reg_addr == msia_pkg::IDX_MEN) nxt_rdata[1:0] = men_ff;
    for (int i = 0; i < msia_pkg::NUM_MATCH; i++) begin
      if (lnk.reg_addr == 5'(msia_pkg::IDX_MADR0 + i)) nxt_rdata[19:0] = madr_ff[i];
    end
    if (lnk.reg_addr == msia_pkg::IDX_SP) nxt_rdata[15:0] = sp_ff;
  end

  // Link answer: done one clock after the request is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
      rdata_ff <= msia_pkg::WORD_RESET;
    end else if (ce) begin
      done_ff <= acc;
      if (acc) rdata_ff <= nxt_rdata;
    end
  end

  // Request to the CPU; match requests bypass global enable and levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_ff <= 1'b0;
      irq_num_ff <= 3'h0;
      irq_lvl_ff <= msia_pkg::LVL_RESET;
    end else if (ce) begin
      irq_req_ff <= sp_set_ff && (m_any || win_ok);
      irq_num_ff <= m_any ? (msia_pkg::MATCH_NUM0 + 3'(m_idx)) : 3'(win_idx);
      irq_lvl_ff <= m_any ? msia_pkg::MATCH_LVL : win_lvl;
    end
  end

  assign lnk.reg_done = done_ff;
  assign lnk.reg_rdata = rdata_ff;
  assign lnk.irq_req = irq_req_ff;
  assign lnk.irq_num = irq_num_ff;
  assign lnk.irq_lvl = irq_lvl_ff;
  assign lnk.saved_pc = spc_ff;
endmodule
`default_nettype wire

// ---- msia_pkg.sv ----
// Shared constants for the multi-source interrupt and address-match block.
// Assumes one 100 MHz clock (pclk) and an active-low asynchronous reset.
package msia_pkg;
  // Link geometry
  localparam int NUM_MS = 4;
  localparam int NUM_MATCH = 2;
  localparam int SRC_W = 8;
  localparam int LVL_W = 3;
  localparam int ADDR_W = 20;
  localparam int IDX_W = 5;
  localparam int DATA_W = 32;

  // Link operations: plain move, bit set, bit clear, read
  typedef enum logic [1:0] {
    OP_WR = 2'b00,
    OP_SET = 2'b01,
    OP_CLR = 2'b10,
    OP_RD = 2'b11
  } msia_op_t;

  // Device register indices on the link
  localparam logic [4:0] IDX_ACK = 5'h00;
  localparam logic [4:0] IDX_STAT0 = 5'h01;
  localparam logic [4:0] IDX_EN0 = 5'h05;
  localparam logic [4:0] IDX_CTL0 = 5'h09;
  localparam logic [4:0] IDX_MEN = 5'h0d;
  localparam logic [4:0] IDX_MADR0 = 5'h0e;
  localparam logic [4:0] IDX_SP = 5'h10;

  // Control register fields
  localparam int CTL_LVL_LSB = 0;
  localparam int CTL_FLAG_BIT = 3;
  // Acknowledge word fields
  localparam int ACK_LVL_LSB = 0;
  localparam int ACK_NUM_LSB = 4;
  localparam int ACK_VLD_BIT = 7;
  localparam logic [2:0] MATCH_NUM0 = 3'h4;
  localparam logic [2:0] MATCH_LVL = 3'h7;

  // Saved program counter steps
  localparam logic [19:0] PC_STEP_LONG = 20'h00002;
  localparam logic [19:0] PC_STEP_SHORT = 20'h00001;

  // Reset values
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] SRC_RESET = 8'h00;
  localparam logic [2:0] LVL_RESET = 3'h0;
  localparam logic [19:0] MADR_RESET = 20'h00000;
  localparam logic [31:0] WORD_RESET = 32'h00000000;

  // Controller APB register offsets
  localparam logic [7:0] HA_CMD = 8'h00;
  localparam logic [7:0] HA_WDATA = 8'h04;
  localparam logic [7:0] HA_RDATA = 8'h08;
  localparam logic [7:0] HA_STATUS = 8'h0c;
  localparam logic [7:0] HA_CPU = 8'h10;
  localparam logic [7:0] HA_FETCH = 8'h14;
  localparam logic [7:0] HA_EVENT = 8'h18;
  localparam logic [7:0] HA_ACKINFO = 8'h1c;
  localparam logic [7:0] HA_SAVEDPC = 8'h20;
endpackage

// ---- msia_link_if.sv ----
// Link between the interrupt controller end and the interrupt logic end.
// Assumes both ends run on the same pclk; no clocking block.
`timescale 1ns/1ps
`default_nettype none
interface msia_link_if;
  // Register access
  logic reg_req;
  msia_pkg::msia_op_t reg_op;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_done;
  logic [31:0] reg_rdata;
  // Peripheral source events
  logic evt_valid;
  logic [1:0] evt_sel;
  logic [7:0] evt_bits;
  // CPU state and instruction fetch
  logic gie;
  logic [2:0] ppl;
  logic fetch_valid;
  logic [19:0] fetch_addr;
  logic fetch_plus2;
  // Request to the CPU sequencer
  logic irq_req;
  logic [2:0] irq_num;
  logic [2:0] irq_lvl;
  logic [19:0] saved_pc;

  modport dev (
    input reg_req, reg_op, reg_addr, reg_wdata, evt_valid, evt_sel, evt_bits,
    input gie, ppl, fetch_valid, fetch_addr, fetch_plus2,
    output reg_done, reg_rdata, irq_req, irq_num, irq_lvl, saved_pc
  );
  modport host (
    output reg_req, reg_op, reg_addr, reg_wdata, evt_valid, evt_sel, evt_bits,
    output gie, ppl, fetch_valid, fetch_addr, fetch_plus2,
    input reg_done, reg_rdata, irq_req, irq_num, irq_lvl, saved_pc
  );
endinterface
`default_nettype wire

// ---- msia_irq_host.sv ----
// Controller end: APB slave registers for software, link master toward the
// interrupt logic, CPU enable state, fetch and event injection, auto acknowledge.
// Assumes an APB master on pclk and the device end on the same clock.
`timescale 1ns/1ps
`default_nettype none
module msia_irq_host (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to interrupt logic
  msia_link_if.host lnk
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_WAIT = 2'b01
  } msia_hst_t;

  msia_hst_t st_ff;
  logic pready_ff, pslverr_ff, go_ff, auto_ff, gie_ff, gie_want_ff, ack_src_ff, ack_pend_ff;
  logic [31:0] prdata_ff, wdata_ff, rdata_ff;
  logic [1:0] cmd_op_ff;
  logic [4:0] cmd_addr_ff;
  logic [2:0] ppl_ff;
  logic [7:0] ackinfo_ff;
  logic req_ff, evt_v_ff, fet_v_ff, fet_p2_ff;
  msia_pkg::msia_op_t op_ff;
  logic [4:0] addr_ff;
  logic [31:0] lwd_ff;
  logic [1:0] evt_sel_ff;
  logic [7:0] evt_bits_ff;
  logic [19:0] fet_addr_ff;
  logic apb_wr, apb_rd, mapped;
  logic [31:0] nxt_prdata;

  assign apb_wr = psel && penable && pwrite && pready_ff;
  assign apb_rd = psel && penable && !pwrite && pready_ff;
  assign mapped = (paddr <= msia_pkg::HA_SAVEDPC) && (paddr[1:0] == 2'b00);

  // APB read view
  always_comb begin
    nxt_prdata = msia_pkg::WORD_RESET;
    case (paddr)
      msia_pkg::HA_CMD: nxt_prdata = {19'h0, cmd_addr_ff, 6'h0, cmd_op_ff};
      msia_pkg::HA_WDATA: nxt_prdata = wdata_ff;
      msia_pkg::HA_RDATA: nxt_prdata = rdata_ff;
      msia_pkg::HA_STATUS: nxt_prdata = {24'h0, lnk.irq_lvl, lnk.irq_num, lnk.irq_req,
                                         (st_ff != H_IDLE) || go_ff};
      msia_pkg::HA_CPU: nxt_prdata = {27'h0, auto_ff, ppl_ff, gie_ff};
      msia_pkg::HA_ACKINFO: nxt_prdata = {23'h0, ack_pend_ff, ackinfo_ff};
      msia_pkg::HA_SAVEDPC: nxt_prdata = {12'h0, lnk.saved_pc};
      default: nxt_prdata = msia_pkg::WORD_RESET;
    endcase
  end

  // One wait state: pready rises in the access phase, the transfer ends next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= msia_pkg::WORD_RESET;
    end else if (ce) begin
      pready_ff <= psel && penable && !pready_ff;
      if (psel && penable && !pready_ff) begin
        prdata_ff <= nxt_prdata;
        pslverr_ff <= !mapped;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Software registers; a go while busy is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_op_ff <= 2'h0;
      cmd_addr_ff <= 5'h0;
      wdata_ff <= msia_pkg::WORD_RESET;
      go_ff <= 1'b0;
      auto_ff <= 1'b0;
      ppl_ff <= msia_pkg::LVL_RESET;
      gie_want_ff <= 1'b0;
    end else if (ce) begin
      if (go_ff && st_ff == H_IDLE) go_ff <= 1'b0;
      if (apb_wr && paddr == msia_pkg::HA_CMD && !go_ff && st_ff == H_IDLE) begin
        cmd_op_ff <= pwdata[1:0];
        cmd_addr_ff <= pwdata[12:8];
        go_ff <= pwdata[2];
      end
      if (apb_wr && paddr == msia_pkg::HA_WDATA) wdata_ff <= pwdata;
      if (apb_wr && paddr == msia_pkg::HA_CPU) begin
        gie_want_ff <= pwdata[0];
        ppl_ff <= pwdata[3:1];
        auto_ff <= pwdata[4];
      end
    end
  end

  // Global enable falls at once but rises only once no link access is in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_ff <= 1'b0;
    end else if (ce) begin
      if (!gie_want_ff) begin
        gie_ff <= 1'b0;
      end else if (st_ff == H_IDLE && !go_ff) begin
        gie_ff <= 1'b1;
      end
    end
  end

  // Link master: software commands first, then the acknowledge sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= H_IDLE;
      req_ff <= 1'b0;
      op_ff <= msia_pkg::OP_RD;
      addr_ff <= 5'h0;
      lwd_ff <= msia_pkg::WORD_RESET;
      rdata_ff <= msia_pkg::WORD_RESET;
      ack_src_ff <= 1'b0;
      ackinfo_ff <= 8'h00;
      ack_pend_ff <= 1'b0;
    end else if (ce) begin
      if (apb_rd && paddr == msia_pkg::HA_ACKINFO) ack_pend_ff <= 1'b0;
      case (st_ff)
        H_IDLE: begin
          if (go_ff) begin
            req_ff <= 1'b1;
            op_ff <= msia_pkg::msia_op_t'(cmd_op_ff);
            addr_ff <= cmd_addr_ff;
            lwd_ff <= wdata_ff;
            ack_src_ff <= 1'b0;
            st_ff <= H_WAIT;
          end else if (auto_ff && lnk.irq_req && !ack_pend_ff) begin
            req_ff <= 1'b1;
            op_ff <= msia_pkg::OP_RD;
            addr_ff <= msia_pkg::IDX_ACK;
            ack_src_ff <= 1'b1;
            st_ff <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (lnk.reg_done) begin
            req_ff <= 1'b0;
            st_ff <= H_IDLE;
            if (ack_src_ff) begin
              ackinfo_ff <= lnk.reg_rdata[7:0];
              ack_pend_ff <= 1'b1;
            end else begin
              rdata_ff <= lnk.reg_rdata;
            end
          end
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  // Event and fetch injection: one-clock strobes from APB writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_v_ff <= 1'b0;
      evt_sel_ff <= 2'h0;
      evt_bits_ff <= msia_pkg::SRC_RESET;
      fet_v_ff <= 1'b0;
      fet_addr_ff <= msia_pkg::MADR_RESET;
      fet_p2_ff <= 1'b0;
    end else if (ce) begin
      evt_v_ff <= apb_wr && paddr == msia_pkg::HA_EVENT;
      fet_v_ff <= apb_wr && paddr == msia_pkg::HA_FETCH;
      if (apb_wr && paddr == msia_pkg::HA_EVENT) begin
        evt_bits_ff <= pwdata[7:0];
        evt_sel_ff <= pwdata[9:8];
      end
      if (apb_wr && paddr == msia_pkg::HA_FETCH) begin
        fet_addr_ff <= pwdata[19:0];
        fet_p2_ff <= pwdata[20];
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign lnk.reg_req = req_ff;
  assign lnk.reg_op = op_ff;
  assign lnk.reg_addr = addr_ff;
  assign lnk.reg_wdata = lwd_ff;
  assign lnk.evt_valid = evt_v_ff;
  assign lnk.evt_sel = evt_sel_ff;
  assign lnk.evt_bits = evt_bits_ff;
  assign lnk.gie = gie_ff;
  assign lnk.ppl = ppl_ff;
  assign lnk.fetch_valid = fet_v_ff;
  assign lnk.fetch_addr = fet_addr_ff;
  assign lnk.fetch_plus2 = fet_p2_ff;
endmodule
`default_nettype wire

// ---- msia_link_sva.sv ----
// Checker for the link between the controller end and the interrupt end.
// Assumes one pclk domain; placed beside the link interface by the bench.
`timescale 1ns/1ps
`default_nettype none
module msia_link_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic reg_req,
  input wire msia_pkg::msia_op_t reg_op,
  input wire logic [4:0] reg_addr,
  input wire logic reg_done,
  input wire logic [2:0] ppl,
  input wire logic fetch_valid,
  input wire logic [19:0] fetch_addr,
  input wire logic fetch_plus2,
  input wire logic irq_req,
  input wire logic [2:0] irq_num,
  input wire logic [2:0] irq_lvl,
  input wire logic [19:0] saved_pc
);
  logic sp_seen_ff;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Remember a taken stack pointer write; requests before it are unsafe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_seen_ff <= 1'b0;
    end else if (reg_req && !reg_done && reg_addr == msia_pkg::IDX_SP &&
                 reg_op != msia_pkg::OP_RD) begin
      sp_seen_ff <= 1'b1;
    end
  end
  sequence s_take;
    reg_req && !reg_done;
  endsequence
  sequence s_answer;
    reg_done ##1 !reg_done;
  endsequence
  sequence s_match_new;
    irq_req && irq_num >= 3'h4 && !$past(irq_req && irq_num >= 3'h4);
  endsequence
  a_done_follows_req: assert property (s_take |=> s_answer)
    else $error("link answer missing or too long");
  a_done_has_cause: assert property (reg_done |-> $past(reg_req) && !$past(reg_done))
    else $error("link answer without request");
  a_irq_num_range: assert property (irq_req |-> irq_num <= 3'h5)
    else $error("request number out of range");
  a_match_top_level: assert property (irq_req && irq_num >= 3'h4 |-> irq_lvl == 3'h7)
    else $error("match request level wrong");
  a_mask_level_gate: assert property (irq_req && irq_num < 3'h4 |-> irq_lvl > $past(ppl))
    else $error("maskable request not above priority");
  a_saved_pc_step: assert property ($changed(saved_pc) |-> saved_pc == $past(fetch_addr) +
    ($past(fetch_plus2) ? 20'h00002 : 20'h00001))
    else $error("saved pc step wrong");
  a_match_before_exec: assert property (s_match_new |-> $past(fetch_valid, 2))
    else $error("match request without fetch");
  a_no_req_unloaded: assert property (!sp_seen_ff |-> !irq_req)
    else $error("request before stack pointer load");
endmodule
`default_nettype wire

// ---- multi_source_irq_and_addr_match_bench.sv ----
// Bench for both ends joined by the link; software side driven over APB.
// Assumes a 100 MHz pclk and reset held for 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module multi_source_irq_and_addr_match_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] c;
  int err_count, checks_done, cyc;
  msia_link_if lnk_bus ();
  msia_irq_dev msia_irq_dev_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .lnk(lnk_bus));
  msia_irq_host msia_irq_host_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk_bus));
  msia_link_sva msia_link_sva_inst (.pclk(pclk), .presetn(presetn), .reg_req(lnk_bus.reg_req),
    .reg_op(lnk_bus.reg_op), .reg_addr(lnk_bus.reg_addr), .reg_done(lnk_bus.reg_done),
    .ppl(lnk_bus.ppl), .fetch_valid(lnk_bus.fetch_valid), .fetch_addr(lnk_bus.fetch_addr),
    .fetch_plus2(lnk_bus.fetch_plus2), .irq_req(lnk_bus.irq_req), .irq_num(lnk_bus.irq_num),
    .irq_lvl(lnk_bus.irq_lvl), .saved_pc(lnk_bus.saved_pc));
  // Clock
  always #5 pclk = ~pclk;
  // Hang guard, well above the roughly one thousand cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Device register access through the command registers; go is never sent while busy
  task automatic lk(input msia_pkg::msia_op_t op, input logic [4:0] i, input logic [31:0] d);
    apb(1'b1, msia_pkg::HA_WDATA, d);
    apb(1'b1, msia_pkg::HA_CMD, {19'h0, i, 6'h01, op});
    q = 32'h1;
    while (q[0] !== 1'b0) apb(1'b0, msia_pkg::HA_STATUS, 32'h0);
    apb(1'b0, msia_pkg::HA_RDATA, 32'h0);
  endtask
  task automatic rdflag(input logic [4:0] ch);
    lk(msia_pkg::OP_RD, msia_pkg::IDX_CTL0 + ch, 32'h0);
    q = 32'(q[3]);
  endtask
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    checks_done = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    lk(msia_pkg::OP_RD, msia_pkg::IDX_SP, 32'h0);
    chk("sp reset", 32'h0, q);
    apb(1'b1, 8'h24, 32'h0);
    chk("unmapped", 32'h1, 32'(slv));
    $display("test reset done");
    // Every channel: unenabled source, enabled source, flag write, second source, clear
    for (c = 5'h0; c < 5'h4; c++) begin
      lk(msia_pkg::OP_WR, msia_pkg::IDX_EN0 + c, 32'h03);
      apb(1'b1, msia_pkg::HA_EVENT, {22'h0, c[1:0], 8'h04});
      rdflag(c);
      chk("flag off", 32'h0, q);
      apb(1'b1, msia_pkg::HA_EVENT, {22'h0, c[1:0], 8'h01});
      rdflag(c);
      chk("flag on", 32'h1, q);
      lk(msia_pkg::OP_WR, msia_pkg::IDX_CTL0 + c, 32'h0);
      rdflag(c);
      chk("flag kept", 32'h1, q);
      apb(1'b1, msia_pkg::HA_EVENT, {22'h0, c[1:0], 8'h02});
      rdflag(c);
      chk("flag two", 32'h1, q);
      lk(msia_pkg::OP_CLR, msia_pkg::IDX_STAT0 + c, 32'h07);
      rdflag(c);
      chk("flag cleared", 32'h0, q);
    end
    $display("test sources done");
    // Acknowledge of channel 2 at level 2
    lk(msia_pkg::OP_WR, msia_pkg::IDX_SP, 32'h0400);
    lk(msia_pkg::OP_WR, msia_pkg::IDX_CTL0 + 5'h2, 32'h2);
    apb(1'b1, msia_pkg::HA_EVENT, {22'h0, 2'h2, 8'h01});
    apb(1'b1, msia_pkg::HA_CPU, 32'h1);
    apb(1'b0, msia_pkg::HA_STATUS, 32'h0);
    chk("irq ch2", 32'h4a, q & 32'hfe);
    lk(msia_pkg::OP_RD, msia_pkg::IDX_ACK, 32'h0);
    chk("ack word", 32'ha2, q & 32'hff);
    lk(msia_pkg::OP_RD, msia_pkg::IDX_STAT0 + 5'h2, 32'h0);
    chk("status kept", 32'h1, q & 32'hff);
    rdflag(5'h2);
    chk("flag back", 32'h1, q);
    apb(1'b1, msia_pkg::HA_CPU, 32'h7);
    apb(1'b0, msia_pkg::HA_STATUS, 32'h0);
    chk("level masked", 32'h0, q & 32'h2);
    apb(1'b1, msia_pkg::HA_CPU, 32'h0);
    apb(1'b0, msia_pkg::HA_STATUS, 32'h0);
    chk("gie masked", 32'h0, q & 32'h2);
    $display("test acknowledge done");
    // Address match with interrupts disabled
    lk(msia_pkg::OP_WR, msia_pkg::IDX_MADR0, 32'h01230);
    lk(msia_pkg::OP_WR, msia_pkg::IDX_MADR0 + 5'h1, 32'h00456);
    lk(msia_pkg::OP_WR, msia_pkg::IDX_MEN, 32'h3);
    apb(1'b1, msia_pkg::HA_FETCH, 32'h00101230);
    // Fetch strobe, pending bit and request are three flops deep
    @(posedge pclk);
    apb(1'b0, msia_pkg::HA_STATUS, 32'h0);
    chk("match0 irq", 32'hf2, q & 32'hfe);
    apb(1'b0, msia_pkg::HA_SAVEDPC, 32'h0);
    chk("pc plus two", 32'h01232, q);
    lk(msia_pkg::OP_RD, msia_pkg::IDX_ACK, 32'h0);
    chk("match0 ack", 32'hc7, q & 32'hff);
    apb(1'b1, msia_pkg::HA_FETCH, 32'h00000456);
    apb(1'b0, msia_pkg::HA_SAVEDPC, 32'h0);
    chk("pc plus one", 32'h00457, q);
    lk(msia_pkg::OP_RD, msia_pkg::IDX_ACK, 32'h0);
    chk("match1 ack", 32'hd7, q & 32'hff);
    $display("test match done");
    // Auto acknowledge of channel 2 by the controller end
    apb(1'b1, msia_pkg::HA_CPU, 32'h11);
    q = 32'h0;
    while (q[8] !== 1'b1) apb(1'b0, msia_pkg::HA_ACKINFO, 32'h0);
    chk("auto ack", 32'h1a2, q);
    $display("test auto done");
    close_out();
  end
endmodule
`default_nettype wire
